// ===== hdl/pst_regs.vh
// Offsets, field positions, reset values for the PLL/serializer/trigger config slice.
// Assumes inclusion by the register bank module only.
//
// Overview of operation
// - Oscillator bias bits 6:0, resets 0x4f
// - One pre-emphasis value drives all lanes
// - Aux enable bit 7 gates buffer, divider
// - Mode codes: 16/32/64 UI clock, timestamp
// - Pin-override layout, resets 0x00
// - Override selects register or pin settings
// - Divided-ref select 0 off, /1 /2 /4
`ifndef PST_REGS_VH
`define PST_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PST_ADDR_BIAS 7'h3f
`define PST_ADDR_PE 7'h48
`define PST_ADDR_AUX 7'h57
`define PST_ADDR_OVR 7'h58

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PST_RST_BIAS 8'h4f
`define PST_RST_PE 8'h00
`define PST_RST_AUX 8'h00
`define PST_RST_OVR 8'h00
`define PST_RST_BIAS_LEVEL 7'h4f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PST_BIAS_MSB 6
`define PST_PE_MSB 3
`define PST_AUX_EN_BIT 7
`define PST_AUX_MODE_MSB 2
`define PST_OVR_EN_BIT 7
`define PST_OVR_SECOND_MSB 5
`define PST_OVR_SECOND_LSB 4
`define PST_OVR_FIRST_MSB 3
`define PST_OVR_FIRST_LSB 2
`define PST_OVR_SE_BIT 1
`define PST_OVR_PLL_EN_BIT 0

// ----------------------------------------------------------------
// Aux output mode codes
// ----------------------------------------------------------------
`define PST_MODE_16UI 3'h0
`define PST_MODE_32UI 3'h1
`define PST_MODE_64UI 3'h2
`define PST_MODE_TSTAMP 3'h3

`endif

// ===== hdl/pst_config_regs.v
// Register bank for PLL bias, lane pre-emphasis, aux trigger output and PLL pin override.
// Assumes a simple synchronous register port from the serial control decoder.
`timescale 1ns/10ps
`include "pst_regs.vh"

module pst_config_regs (
  input wire clk,
  input wire reset,
  input wire clk_en,
  input wire [6:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire pin_pll_enable,
  input wire pin_single_ended_ref,
  input wire [1:0] pin_first_divided_ref_select,
  input wire [1:0] pin_second_divided_ref_select,
  input wire serializer_reinit,
  input wire timestamp_input,
  output reg [6:0] oscillator_bias_level,
  output reg [3:0] lane_preemphasis_level,
  output reg aux_output_enable,
  output reg [2:0] aux_output_mode,
  output reg aux_clock_from_serializer,
  output reg [6:0] aux_divide_ui,
  output reg aux_timestamp_out,
  output reg pll_enable,
  output reg single_ended_ref_select,
  output reg [2:0] first_divided_ref_out,
  output reg [2:0] second_divided_ref_out
);

  // ----------------------------------------------------------------
  // Behaviour notes
  // ----------------------------------------------------------------
  // Mode changes while enabled are taken as written; keep enable clear.
  // Reserved bits are stored so read-back matches the last write.
  // Config pins and the timestamp pin come from outside, so are resampled.

  // ----------------------------------------------------------------
  // Storage and decode
  // ----------------------------------------------------------------
  reg [7:0] bias_reg;
  reg [7:0] pe_reg;
  reg [7:0] aux_reg;
  reg [7:0] ovr_reg;
  reg [2:0] ts_sync;
  reg [1:0] eff_first;
  reg [1:0] eff_second;
  reg eff_pll_en;
  reg eff_se;
  reg [7:0] next_rdata;
  reg [5:0] pin_s1;
  reg [5:0] pin_s2;
  reg [5:0] pin_s3;
  reg [5:0] pin_stable;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Divided-ref code to one-hot divider: bit0 /1, bit1 /2, bit2 /4
  // Shared by both divided-reference outputs
  function [2:0] div_decode;
    input [1:0] code;
    begin
      case (code)
        2'h1: div_decode = 3'h1;
        2'h2: div_decode = 3'h2;
        2'h3: div_decode = 3'h4;
        default: div_decode = 3'h0;
      endcase
    end
  endfunction

  // Aux mode to divide ratio in unit intervals
  function [6:0] ui_decode;
    input [2:0] mode;
    begin
      case (mode)
        `PST_MODE_16UI: ui_decode = 7'h10;
        `PST_MODE_32UI: ui_decode = 7'h20;
        `PST_MODE_64UI: ui_decode = 7'h40;
        default: ui_decode = 7'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Register storage and read-back
  // ----------------------------------------------------------------
  // Register writes, all bits stored including reserved
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      bias_reg <= `PST_RST_BIAS;
      pe_reg <= `PST_RST_PE;
      aux_reg <= `PST_RST_AUX;
      ovr_reg <= `PST_RST_OVR;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `PST_ADDR_BIAS) begin
        bias_reg <= reg_wdata;
      end else if (reg_addr == `PST_ADDR_PE) begin
        pe_reg <= reg_wdata;
      end else if (reg_addr == `PST_ADDR_AUX) begin
        aux_reg <= reg_wdata;
      end else if (reg_addr == `PST_ADDR_OVR) begin
        ovr_reg <= reg_wdata;
      end
    end
  end

  // Read mux, unmapped reads return zero
  // Read data is registered, so it trails the address by one edge
  always @* begin
    if (reg_addr == `PST_ADDR_BIAS) begin
      next_rdata = bias_reg;
    end else if (reg_addr == `PST_ADDR_PE) begin
      next_rdata = pe_reg;
    end else if (reg_addr == `PST_ADDR_AUX) begin
      next_rdata = aux_reg;
    end else if (reg_addr == `PST_ADDR_OVR) begin
      next_rdata = ovr_reg;
    end else begin
      next_rdata = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // PLL setting selection
  // ----------------------------------------------------------------
  // Pin-or-register selection of PLL settings
  always @* begin
    if (ovr_reg[`PST_OVR_EN_BIT]) begin
      eff_pll_en = ovr_reg[`PST_OVR_PLL_EN_BIT];
      eff_se = ovr_reg[`PST_OVR_SE_BIT];
      eff_first = ovr_reg[`PST_OVR_FIRST_MSB:`PST_OVR_FIRST_LSB];
      eff_second = ovr_reg[`PST_OVR_SECOND_MSB:`PST_OVR_SECOND_LSB];
    end else begin
      eff_pll_en = pin_stable[5];
      eff_se = pin_stable[4];
      eff_first = pin_stable[3:2];
      eff_second = pin_stable[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Input resampling
  // ----------------------------------------------------------------
  // Config pins, three stages; a bit moves once stages two and three agree
  // Bit order: PLL enable, single-ended ref, first select, second select
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
      pin_s3 <= 6'h00;
      pin_stable <= 6'h00;
    end else if (clk_en) begin
      pin_s1 <= {pin_pll_enable, pin_single_ended_ref,
        pin_first_divided_ref_select, pin_second_divided_ref_select};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      // Both agree high sets, both low clears, a split holds
      pin_stable <= (pin_s2 & pin_s3) | (pin_stable & (pin_s2 | pin_s3));
    end
  end

  // Timestamp resampler, three stages
  // Only the first stage sees the raw pin
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ts_sync <= 3'h0;
    end else if (clk_en) begin
      ts_sync <= {ts_sync[1:0], timestamp_input};
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Registered outputs
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      oscillator_bias_level <= `PST_RST_BIAS_LEVEL;
      lane_preemphasis_level <= 4'h0;
      aux_output_enable <= 1'b0;
      aux_output_mode <= 3'h0;
      aux_clock_from_serializer <= 1'b0;
      aux_divide_ui <= 7'h00;
      aux_timestamp_out <= 1'b0;
      pll_enable <= 1'b0;
      single_ended_ref_select <= 1'b0;
      first_divided_ref_out <= 3'h0;
      second_divided_ref_out <= 3'h0;
    end else if (clk_en) begin
      // Register-held levels
      reg_rdata <= next_rdata;
      oscillator_bias_level <= bias_reg[`PST_BIAS_MSB:0];
      lane_preemphasis_level <= pe_reg[`PST_PE_MSB:0];
      aux_output_enable <= aux_reg[`PST_AUX_EN_BIT];
      aux_output_mode <= aux_reg[`PST_AUX_MODE_MSB:0];
      // Clock modes come from serializer, gated by enable and reinit
      aux_clock_from_serializer <= aux_reg[`PST_AUX_EN_BIT] && !serializer_reinit &&
        (aux_reg[`PST_AUX_MODE_MSB:0] <= `PST_MODE_64UI);
      aux_divide_ui <= aux_reg[`PST_AUX_EN_BIT] ?
        ui_decode(aux_reg[`PST_AUX_MODE_MSB:0]) : 7'h00;
      // Timestamp once second and third stage agree
      if (aux_reg[`PST_AUX_EN_BIT] && aux_reg[`PST_AUX_MODE_MSB:0] == `PST_MODE_TSTAMP) begin
        if (ts_sync[1] == ts_sync[2]) begin
          aux_timestamp_out <= ts_sync[2];
        end
      end else begin
        aux_timestamp_out <= 1'b0;
      end
      // PLL settings from pins or override
      pll_enable <= eff_pll_en;
      single_ended_ref_select <= eff_se;
      first_divided_ref_out <= div_decode(eff_first);
      // Second output runs only with the first
      second_divided_ref_out <= (eff_first != 2'h0) ? div_decode(eff_second) : 3'h0;
    end
  end

endmodule // pst_config_regs

// ===== verification/pst_config_regs_assertions.sv
// Port assertions for the config register bank.
// Assumes one clock and an async active-high reset.
`timescale 1ns/10ps
module pst_config_regs_assertions (
  input wire clk,
  input wire reset,
  input wire clk_en,
  input wire [6:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [6:0] oscillator_bias_level,
  input wire [3:0] lane_preemphasis_level,
  input wire aux_output_enable,
  input wire [2:0] aux_output_mode,
  input wire aux_clock_from_serializer,
  input wire [6:0] aux_divide_ui,
  input wire aux_timestamp_out,
  input wire pll_enable,
  input wire [2:0] first_divided_ref_out,
  input wire [2:0] second_divided_ref_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  bias_write_a: assert property (clk_en && reg_wr && reg_addr == 7'h3f ##1 clk_en
    |=> oscillator_bias_level == $past(reg_wdata[6:0], 2)) else $error("bias write");
  lane_write_a: assert property (clk_en && reg_wr && reg_addr == 7'h48 ##1 clk_en
    |=> lane_preemphasis_level == $past(reg_wdata[3:0], 2)) else $error("lane write");
  aux_gate_a: assert property (!aux_output_enable
    |-> aux_divide_ui == 7'h00 && !aux_timestamp_out) else $error("aux gate");
  aux_clock_a: assert property (aux_output_enable && aux_output_mode <= 3'h2
    |-> aux_divide_ui == (7'h10 << aux_output_mode)) else $error("aux divide");
  serdes_src_a: assert property (aux_clock_from_serializer
    |-> aux_output_enable && aux_output_mode <= 3'h2) else $error("serdes source");
  second_ref_a: assert property (second_divided_ref_out != 3'h0
    |-> first_divided_ref_out != 3'h0) else $error("second ref alone");
  ovr_pll_a: assert property (clk_en && reg_wr && reg_addr == 7'h58 && reg_wdata[7]
    ##1 clk_en |=> pll_enable == $past(reg_wdata[0], 2)) else $error("override pll");
  read_back_a: assert property (clk_en && reg_wr && reg_addr == 7'h57
    ##1 clk_en && !reg_wr && reg_addr == 7'h57 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("read back");
endmodule // pst_config_regs_assertions
bind pst_config_regs pst_config_regs_assertions u_chk (.clk, .reset, .clk_en, .reg_addr,
  .reg_wr, .reg_wdata, .reg_rdata, .oscillator_bias_level, .lane_preemphasis_level,
  .aux_output_enable, .aux_output_mode, .aux_clock_from_serializer, .aux_divide_ui,
  .aux_timestamp_out, .pll_enable, .first_divided_ref_out, .second_divided_ref_out);

// ===== verification/pst_host_model.sv
// Host model driving the register port off the falling edge.
// Assumes callers keep reserved bits at reset values.
`timescale 1ns/10ps
module pst_host_model (
  input wire clk,
  input wire [7:0] reg_rdata,
  output reg [6:0] reg_addr,
  output reg reg_wr,
  output reg [7:0] reg_wdata
);
  initial begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // Write, then hold address; data inverted once released
  task wr(input [6:0] a, input [7:0] d);
    begin
      @(negedge clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge clk) {reg_wdata, reg_wr} = {~d, 1'b0};
      @(negedge clk);
    end
  endtask
  // Read: data one edge after the address
  task rd(input [6:0] a, output [7:0] d);
    begin
      @(negedge clk) reg_addr = a;
      @(negedge clk) d = reg_rdata;
    end
  endtask
endmodule // pst_host_model

// ===== verification/tb_pst_config_regs.sv
// Self-checking bench for the config register bank.
// Assumes the host model owns the register port.
`timescale 1ns/10ps
module tb_pst_config_regs;
  reg clk = 1'b0, reset = 1'b1, clk_en = 1'b1, pin_pll_enable = 1'b1;
  reg pin_single_ended_ref = 1'b1, serializer_reinit = 1'b0, timestamp_input = 1'b1;
  reg [1:0] pin_first_divided_ref_select = 2'h2, pin_second_divided_ref_select = 2'h3;
  wire [6:0] reg_addr, oscillator_bias_level, aux_divide_ui;
  wire reg_wr, aux_output_enable, aux_clock_from_serializer, aux_timestamp_out;
  wire pll_enable, single_ended_ref_select;
  wire [7:0] reg_wdata, reg_rdata;
  wire [3:0] lane_preemphasis_level;
  wire [2:0] aux_output_mode, first_divided_ref_out, second_divided_ref_out;
  integer err_count = 0, n_checks = 0, cyc = 0, i;
  reg [7:0] rd;
  pst_config_regs u_dut (.clk, .reset, .clk_en, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
    .pin_pll_enable, .pin_single_ended_ref, .pin_first_divided_ref_select,
    .pin_second_divided_ref_select, .serializer_reinit, .timestamp_input,
    .oscillator_bias_level, .lane_preemphasis_level, .aux_output_enable, .aux_output_mode,
    .aux_clock_from_serializer, .aux_divide_ui, .aux_timestamp_out, .pll_enable,
    .single_ended_ref_select, .first_divided_ref_out, .second_divided_ref_out);
  pst_host_model u_host (.clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata);
  initial forever #5 clk = ~clk;
  // Cycle ceiling
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_count = err_count + 1;
      final_report;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task rdc(input [6:0] a, input [7:0] e);
    begin
      u_host.rd(a, rd);
      chk(rd, e);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task t_regs;
    begin
      chk({1'b0, oscillator_bias_level}, 8'h4f);
      rdc(7'h3f, 8'h4f);
      rdc(7'h48, 8'h00);
      rdc(7'h57, 8'h00);
      rdc(7'h58, 8'h00);
      rdc(7'h11, 8'h00);
      u_host.wr(7'h3f, 8'h4a);
      chk({1'b0, oscillator_bias_level}, 8'h4a);
      rdc(7'h3f, 8'h4a);
      u_host.wr(7'h48, 8'h0f);
      clk_en = 1'b0;
      u_host.wr(7'h48, 8'h03);
      clk_en = 1'b1;
      chk({4'h0, lane_preemphasis_level}, 8'h0f);
      rdc(7'h48, 8'h0f);
    end
  endtask
  task t_reinit;
    begin
      @(negedge clk) serializer_reinit = 1'b1;
      @(negedge clk) chk({7'h0, aux_clock_from_serializer}, 8'h00);
      serializer_reinit = 1'b0;
      @(negedge clk) chk({7'h0, aux_clock_from_serializer}, 8'h01);
    end
  endtask
  task t_tstamp;
    begin
      timestamp_input = 1'b0;
      repeat (3) @(negedge clk);
      chk({7'h0, aux_timestamp_out}, 8'h01);
      @(negedge clk) chk({7'h0, aux_timestamp_out}, 8'h00);
      timestamp_input = 1'b1;
      repeat (4) @(negedge clk);
      chk({7'h0, aux_timestamp_out}, 8'h01);
    end
  endtask
  task t_aux;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        u_host.wr(7'h57, i[7:0]);
        u_host.wr(7'h57, 8'h80 | i[7:0]);
        chk({7'h0, aux_output_enable}, 8'h01);
        chk({5'h0, aux_output_mode}, i[7:0]);
        chk({1'b0, aux_divide_ui}, i < 3 ? 8'h10 << i : 8'h00);
        chk({7'h0, aux_timestamp_out}, {7'h0, i == 3});
        chk({7'h0, aux_clock_from_serializer}, {7'h0, i < 3});
        if (i == 0) t_reinit;
        if (i == 3) t_tstamp;
        u_host.wr(7'h57, i[7:0]);
        chk({7'h0, aux_output_enable}, 8'h00);
        chk({7'h0, aux_timestamp_out}, 8'h00);
      end
      u_host.wr(7'h57, 8'h00);
      chk({1'b0, aux_divide_ui}, 8'h00);
    end
  endtask
  task t_ovr;
    begin
      chk({pll_enable, single_ended_ref_select, first_divided_ref_out,
        second_divided_ref_out}, 8'hd4);
      u_host.wr(7'h58, 8'h8d);
      chk({pll_enable, first_divided_ref_out}, 8'h0c);
      u_host.wr(7'h58, 8'hb2);
      chk({pll_enable, single_ended_ref_select, first_divided_ref_out,
        second_divided_ref_out}, 8'h40);
      rdc(7'h58, 8'hb2);
      u_host.wr(7'h58, 8'h99);
      chk({pll_enable, single_ended_ref_select, first_divided_ref_out,
        second_divided_ref_out}, 8'h91);
      u_host.wr(7'h58, 8'h00);
      chk({pll_enable, single_ended_ref_select, first_divided_ref_out,
        second_divided_ref_out}, 8'hd4);
    end
  endtask
  task t_reset;
    begin
      u_host.wr(7'h48, 8'h05);
      reset = 1'b1;
      repeat (2) @(negedge clk);
      chk({1'b0, oscillator_bias_level}, 8'h4f);
      chk({4'h0, lane_preemphasis_level}, 8'h00);
      reset = 1'b0;
      rdc(7'h48, 8'h00);
      rdc(7'h58, 8'h00);
      u_host.wr(7'h3f, 8'h4a);
      chk({1'b0, oscillator_bias_level}, 8'h4a);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    t_regs;
    t_aux;
    t_ovr;
    t_reset;
    final_report;
  end
endmodule // tb_pst_config_regs
